// File: rtl/ivec_arbiter.sv
/*
 Combinational priority resolver: picks the pending source with the highest
 level, earliest in polling order on a tie. Assumes inputs are registered.
*/
`timescale 1ns/100ps
module ivec_arbiter
	import ivec_pkg::*;
(
	input  wire logic [ivec_pkg::NSRC-1:0] pend,
	input  wire logic [ivec_pkg::NGRP-1:0] prio_hi,
	input  wire logic [ivec_pkg::NGRP-1:0] prio_lo,
	output logic                           win_ok,
	output logic [3:0]                     win_idx,
	output logic [1:0]                     win_lvl
);
	import ivec_pkg::*;

	logic [1:0] src_lvl [NSRC];

	// Per-source level from its group's bit pair
	genvar gi;
	generate
		for (gi = 0; gi < NSRC; gi++)
		begin : g_lvl
			assign src_lvl[gi] = ivec_lvl(prio_hi, prio_lo, 4'(gi));
		end
	endgenerate

	// Scan last to first so an equal level earlier in order overrides
	always_comb
	begin
		win_ok = 1'b0;
		win_idx = 4'h0;
		win_lvl = 2'h0;
		for (int i = NSRC - 1; i >= 0; i--)
		begin
			if (pend[i] && (!win_ok || src_lvl[i] >= win_lvl))
			begin
				win_ok = 1'b1;
				win_idx = 4'(i);
				win_lvl = src_lvl[i];
			end
		end
	end

endmodule : ivec_arbiter

// File: rtl/ivec_ctrl.sv
/*
 Interrupt priority and vectoring controller with APB register access.
 Assumes one pclk domain, a core that pulses reti_i once per handler return,
 and APB masters that follow the usual setup and access sequence.
*/
// The APB register port and the placing of the registers were left to the implementer.
// Overview of operation
// - Eleven sources form six priority groups
// - Each group level from two register bits
// - Bit pair high first, 11 is highest
// - Equal-level ties go to polling order
// - Fixed polling order ext0 through ext6
// - Source requests only while its enable set
// - Own flags; ext0-5 cleared on entry
// - Transfer and tick ORed onto ext6
// - Vectors for ext0, timers, ext1, serial0
// - Vectors for serial1, ext2 through ext6
// - Watchdog status bit has no effect
// - No take while equal/higher service runs
// - Response is detect plus six cycles
`timescale 1ns/100ps
module ivec_ctrl
	import ivec_pkg::*;
(
	input  wire logic                pclk,
	input  wire logic                presetn,
	input  wire logic [7:0]          paddr,
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [31:0]         pwdata,
	output logic [31:0]              prdata,
	output logic                     pready,
	output logic                     pslverr,
	input  wire ivec_pkg::ivec_evt_t evt_i,
	input  wire logic                reti_i,
	output ivec_pkg::ivec_core_t     core_o,
	output logic                     irq_o
);
	import ivec_pkg::*;

	logic [NFLG-1:0] en_r;
	logic [NFLG-1:0] flg_r;
	logic [NFLG-1:0] flg_nxt;
	logic [NGRP-1:0] plo_r;
	logic [NGRP-1:0] phi_r;
	logic            watchdog_status_bit_r;
	logic [3:0]      isr_r;
	logic [3:0]      isr_nxt;
	ivec_state_t     st_r;
	logic [2:0]      cnt_r;
	logic [3:0]      idx_r;
	logic [1:0]      lvl_r;
	logic            ext6_prev_r;
	logic [31:0]     prdata_r;
	logic            pready_r;
	logic            pslverr_r;
	logic            irq_r;
	ivec_core_t      core_r;

	logic            acc;
	logic            wr;
	logic            mapped;
	logic            ext6_lvl;
	logic            ext6_rise;
	logic [NSRC-1:0] pend;
	logic            win_ok;
	logic [3:0]      win_idx;
	logic [1:0]      win_lvl;
	logic [2:0]      top;
	logic            take;
	logic            enter;

	// Highest level in service: {found, level}
	function automatic logic [2:0] top_level(input logic [3:0] v);
		logic [2:0] r;
		r = 3'h0;
		for (int l = 0; l < 4; l++)
		begin
			if (v[l])
			begin
				r = {1'b1, 2'(l)};
			end
		end
		return r;
	endfunction : top_level

	// One-hot of a level
	function automatic logic [3:0] lvl_bit(input logic [1:0] l);
		return 4'h1 << l;
	endfunction : lvl_bit

	// Address decode, shared by write and error logic
	function automatic logic is_mapped(input logic [7:0] a);
		return a == OFS_ENABLE || a == OFS_PRIO_LO || a == OFS_PRIO_HI ||
			a == OFS_FLAGS || a == OFS_STATUS;
	endfunction : is_mapped

	// APB access phase completes in the cycle pready_r is high
	assign acc = psel && penable && pready_r;
	assign wr = acc && pwrite && is_mapped(paddr);
	assign mapped = is_mapped(paddr);

	// Registered pready gives exactly one access cycle, no extra wait
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
		end
		else
		begin
			pready_r <= psel && !penable;
			pslverr_r <= psel && !penable && !mapped;
		end
	end

	// Read data is captured at the setup edge so it is stable in access
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata_r <= 32'h0000_0000;
		end
		else if (psel && !penable && !pwrite)
		begin
			case (paddr)
				OFS_ENABLE: prdata_r <= {19'h0, en_r};
				OFS_PRIO_LO: prdata_r <= {25'h0, watchdog_status_bit_r, plo_r};
				OFS_PRIO_HI: prdata_r <= {26'h0, phi_r};
				OFS_FLAGS: prdata_r <= {19'h0, flg_r};
				OFS_STATUS: prdata_r <= {16'h0, core_r.vec[7:0], 2'h0,
					lvl_r, 1'b0, st_r == ST_CALL, isr_r[1:0] != 2'h0, |isr_r};
				default: prdata_r <= 32'h0000_0000;
			endcase
		end
	end

	// Enable and priority registers
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			en_r <= ENABLE_RST;
			plo_r <= PRIO_RST;
			phi_r <= PRIO_RST;
			watchdog_status_bit_r <= 1'b0;
		end
		else if (wr)
		begin
			if (paddr == OFS_ENABLE)
			begin
				en_r <= pwdata[NFLG-1:0];
			end
			if (paddr == OFS_PRIO_LO)
			begin
				plo_r <= pwdata[NGRP-1:0];
				watchdog_status_bit_r <= pwdata[WATCHDOG_STATUS_BIT_BIT];
			end
			if (paddr == OFS_PRIO_HI)
			begin
				phi_r <= pwdata[NGRP-1:0];
			end
		end
	end

	// Ext6 fires on the rising edge of the enabled transfer/tick OR
	assign ext6_lvl = (flg_r[XFER_BIT] && en_r[XFER_BIT]) ||
		(flg_r[SEC_BIT] && en_r[SEC_BIT]);
	assign ext6_rise = ext6_lvl && !ext6_prev_r;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ext6_prev_r <= 1'b0;
		end
		else
		begin
			ext6_prev_r <= ext6_lvl;
		end
	end

	// Flags: hardware set wins over auto-clear and software write-one-clear
	always_comb
	begin
		flg_nxt = flg_r;
		if (wr && paddr == OFS_FLAGS)
		begin
			flg_nxt = flg_nxt & ~pwdata[NFLG-1:0];
		end
		if (enter && AUTOCLR_MASK[idx_r])
		begin
			flg_nxt[idx_r] = 1'b0;
		end
		flg_nxt = flg_nxt | {evt_i.sec, evt_i.xfer, ext6_rise, evt_i.src};
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			flg_r <= FLAGS_RST;
		end
		else
		begin
			flg_r <= flg_nxt;
		end
	end

	// Only enabled flags compete
	assign pend = flg_r[NSRC-1:0] & en_r[NSRC-1:0];

	ivec_arbiter u_arb (
		.pend    (pend),
		.prio_hi (phi_r),
		.prio_lo (plo_r),
		.win_ok  (win_ok),
		.win_idx (win_idx),
		.win_lvl (win_lvl)
	);

	// Take only above the level now in service
	assign top = top_level(isr_r);
	assign take = st_r == ST_IDLE && win_ok &&
		(!top[2] || win_lvl > top[1:0]);
	assign enter = st_r == ST_CALL && cnt_r == 3'h0;

	// Detect cycle then six call cycles; choice is frozen during the call
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			st_r <= ST_IDLE;
			cnt_r <= 3'h0;
			idx_r <= 4'h0;
			lvl_r <= 2'h0;
		end
		else
		begin
			case (st_r)
				ST_IDLE:
				begin
					if (take)
					begin
						st_r <= ST_CALL;
						cnt_r <= CALL_CNT_INIT;
						idx_r <= win_idx;
						lvl_r <= win_lvl;
					end
				end
				ST_CALL:
				begin
					if (cnt_r == 3'h0)
					begin
						st_r <= ST_IDLE;
					end
					else
					begin
						cnt_r <= cnt_r - 3'h1;
					end
				end
				default: st_r <= ST_IDLE;
			endcase
		end
	end

	// Service levels: return ends the top level, entry opens a new one
	always_comb
	begin
		isr_nxt = isr_r;
		if (reti_i && top[2])
		begin
			isr_nxt = isr_nxt & ~lvl_bit(top[1:0]);
		end
		if (enter)
		begin
			isr_nxt = isr_nxt | lvl_bit(lvl_r);
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			isr_r <= ISR_RST;
		end
		else
		begin
			isr_r <= isr_nxt;
		end
	end

	// Call pulse to the core with the fixed vector of the source
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			core_r <= '0;
		end
		else
		begin
			core_r.call <= enter;
			if (enter)
			begin
				core_r.lvl <= lvl_r;
				core_r.vec <= VEC_TAB[idx_r];
			end
		end
	end

	// Level interrupt: any enabled flag still set
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			irq_r <= 1'b0;
		end
		else
		begin
			irq_r <= |(flg_r & en_r);
		end
	end

	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;
	assign core_o = core_r;
	assign irq_o = irq_r;

	// Helper for priority checks
	logic higher_pend;
	always_comb
	begin
		higher_pend = 1'b0;
		for (int i = 0; i < NSRC; i++)
		begin
			if (pend[i] && ivec_lvl(phi_r, plo_r, 4'(i)) > win_lvl)
			begin
				higher_pend = 1'b1;
			end
		end
	end

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	AST_LATENCY: assert property (take |=> ##5 core_r.call == 1'b0 ##1 core_r.call)
		else $error("call not seven cycles after detect");
	AST_VECTOR: assert property (enter |=> core_r.vec == VEC_TAB[$past(idx_r)])
		else $error("wrong vector");
	AST_ENABLED: assert property (take |-> en_r[win_idx] && flg_r[win_idx])
		else $error("disabled source taken");
	AST_AUTOCLR: assert property (enter && AUTOCLR_MASK[idx_r] &&
		!(idx_r < 4'ha && evt_i.src[idx_r]) |=> !flg_r[$past(idx_r)])
		else $error("flag not cleared on entry");
	AST_SWFLAG: assert property ($fell(flg_r[EXT6_BIT]) |-> $past(wr && paddr == OFS_FLAGS))
		else $error("ext6 flag cleared by hardware");
	AST_PRIO_MAX: assert property (win_ok |-> !higher_pend)
		else $error("lower level won");
	AST_TIE: assert property (win_ok && win_idx != 4'h0 && pend[0] |->
		ivec_lvl(phi_r, plo_r, 4'h0) < win_lvl)
		else $error("polling order broken");
	AST_NO_EQUAL: assert property (take |-> (isr_r >> win_lvl) == 4'h0)
		else $error("equal level taken in service");
	AST_PREEMPT: assert property (enter |=> isr_r[$past(lvl_r)])
		else $error("entered level not in service");
	AST_IRQ: assert property (irq_r == $past(|(flg_r & en_r), 1))
		else $error("irq out of step with flags");

	COV_CALL: cover property (core_r.call);
	COV_NEST: cover property (enter && top[2]);
	COV_EXT6: cover property (ext6_rise);
	COV_TIE: cover property (win_ok && $countones(pend) > 1);

endmodule : ivec_ctrl

// File: rtl/ivec_pkg.sv
/*
 Shared constants, types and decode helpers for the interrupt priority and
 vectoring block. Assumes a single pclk domain and one machine cycle per pclk.
*/
package ivec_pkg;

	// Sources are numbered in polling order; source i belongs to group i/2
	localparam int NSRC = 11;
	localparam int NGRP = 6;
	localparam int NFLG = 13;

	// APB byte offsets
	localparam logic [7:0] OFS_ENABLE = 8'h00;
	localparam logic [7:0] OFS_PRIO_LO = 8'h04;
	localparam logic [7:0] OFS_PRIO_HI = 8'h08;
	localparam logic [7:0] OFS_FLAGS = 8'h0c;
	localparam logic [7:0] OFS_STATUS = 8'h10;

	// Field positions
	localparam int EXT6_BIT = 10;
	localparam int XFER_BIT = 11;
	localparam int SEC_BIT = 12;
	localparam int WATCHDOG_STATUS_BIT_BIT = 6;

	// Reset values
	localparam logic [NFLG-1:0] ENABLE_RST = 13'h0000;
	localparam logic [NFLG-1:0] FLAGS_RST = 13'h0000;
	localparam logic [NGRP-1:0] PRIO_RST = 6'h00;
	localparam logic [3:0] ISR_RST = 4'h0;

	// Long call takes six cycles after the detect cycle
	localparam int CALL_CYCLES = 6;
	localparam logic [2:0] CALL_CNT_INIT = 3'(CALL_CYCLES - 1);

	// Flags cleared by hardware on handler entry (ext0..5, timers)
	localparam logic [NSRC-1:0] AUTOCLR_MASK = 11'h2fd;

	// Vector per source, polling order
	localparam logic [15:0] VEC_TAB [NSRC] = '{
		16'h0003, 16'h0083, 16'h000b, 16'h004b, 16'h0013, 16'h0053,
		16'h001b, 16'h005b, 16'h0023, 16'h0063, 16'h006b};

	typedef enum logic [0:0] {
		ST_IDLE = 1'b0,
		ST_CALL = 1'b1
	} ivec_state_t;

	// Peripheral event pulses; src holds polling slots 0..9
	typedef struct packed {
		logic       sec;
		logic       xfer;
		logic [9:0] src;
	} ivec_evt_t;

	// Toward the core: call pulse with level and vector
	typedef struct packed {
		logic        call;
		logic [1:0]  lvl;
		logic [15:0] vec;
	} ivec_core_t;

	// Level of a source: high bit from the high register, low from the low
	function automatic logic [1:0] ivec_lvl(
		input logic [NGRP-1:0] hi,
		input logic [NGRP-1:0] lo,
		input logic [3:0]      idx
	);
		logic [2:0] g;
		g = idx[3:1];
		return {hi[g], lo[g]};
	endfunction : ivec_lvl

endpackage : ivec_pkg

// File: verif/ivec_core_model.sv
/*
 Behavioural processor core for the interrupt block: counts open handlers
 and returns from the newest one after a programmable wait.
 Assumes one pclk domain and a one-cycle call pulse from the block.
*/
`timescale 1ns/100ps
module ivec_core_model
	import ivec_pkg::*;
(
	input  wire logic                 pclk,
	input  wire logic                 presetn,
	input  wire ivec_pkg::ivec_core_t core_i,
	input  wire logic                 hold,
	input  wire logic [3:0]           delay,
	output logic                      reti_o
);
	logic [3:0] depth_r;
	logic [3:0] cnt_r;

	// Handler stack; a nested call restarts the wait, hold stalls returns
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			depth_r <= 4'h0;
			cnt_r   <= 4'h0;
			reti_o  <= 1'b0;
		end
		else
		begin
			reti_o <= 1'b0;
			if (core_i.call)
			begin
				depth_r <= depth_r + 4'h1;
				cnt_r   <= 4'h0;
			end
			else if (depth_r != 4'h0 && !hold)
			begin
				if (cnt_r == delay)
				begin
					reti_o  <= 1'b1;
					depth_r <= depth_r - 4'h1;
					cnt_r   <= 4'h0;
				end
				else
					cnt_r <= cnt_r + 4'h1;
			end
		end
	end

endmodule : ivec_core_model

// File: verif/ivec_ctrl_test.sv
/*
 Self-checking bench for the interrupt controller: APB tasks, event pulses,
 vector, order, level, preemption, enable and ext6 scenarios.
 Assumes the core model answers each call with one return pulse.
*/
`timescale 1ns/100ps
module ivec_ctrl_test;
	import ivec_pkg::*;
	// Expected vectors in polling order, ext6 last
	localparam logic [15:0] VEXP [11] = '{16'h0003, 16'h0083, 16'h000b, 16'h004b,
		16'h0013, 16'h0053, 16'h001b, 16'h005b, 16'h0023, 16'h0063, 16'h006b};
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, hold = 0;
	logic [7:0]  paddr = '0;
	logic [31:0] pwdata = '0, prdata, rd;
	logic        pready, pslverr, reti_i, irq_o, er;
	logic [3:0]  dly = 4'd10;
	ivec_evt_t   evt_i = '0;
	ivec_core_t  core_o;
	int          checks = 0, mismatches = 0, n;

	// 25 MHz clock
	always #20 pclk = ~pclk;

	ivec_ctrl dut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
		.pready, .pslverr, .evt_i, .reti_i, .core_o, .irq_o);
	ivec_core_model core (.pclk, .presetn, .core_i(core_o), .hold, .delay(dly), .reti_o(reti_i));

	// Verdict in one place
	task automatic end_sim;
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : end_sim

	// Compare and count
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	// One APB transfer; request held until pready is sampled high
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		int k;
		@(posedge pclk);
		psel   <= 1'b1;
		paddr  <= a;
		pwrite <= wr;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do
		begin
			@(posedge pclk);
			k++;
		end
		while (pready !== 1'b1 && k < 20);
		rd = prdata;
		er = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1)
		begin
			mismatches++;
			$display("BAD %0t no pready", $time);
			end_sim;
		end
	endtask : apb

	// Pulse events for one cycle; returns at the edge that samples them
	task automatic fire(input logic [11:0] m);
		@(posedge pclk);
		evt_i <= ivec_evt_t'(m);
		@(posedge pclk);
		evt_i <= '0;
	endtask : fire

	// Count edges until a call is seen, at most lim; a missing expected call ends the run
	task automatic wait_call(input int lim, input bit must = 1'b1);
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (core_o.call !== 1'b1 && n < lim);
		if (must && core_o.call !== 1'b1)
		begin
			mismatches++;
			$display("BAD %0t no call", $time);
			end_sim;
		end
	endtask : wait_call

	task automatic idle(input int c);
		repeat (c) @(posedge pclk);
	endtask : idle

	// Reset values and an unmapped address
	task automatic t_reset;
		for (int a = 0; a < 20; a += 4)
		begin
			apb(1'b0, 8'(a), 32'h0);
			chk(rd, 32'h0);
			chk(32'(er), 32'h0);
		end
		apb(1'b0, 8'h14, 32'h0);
		chk(32'(er), 32'h1);
	endtask : t_reset

	// Slots 0 to 9 alone: vector, latency, flag clearing
	task automatic t_vectors;
		for (int s = 0; s < 10; s++)
		begin
			fire(12'(1 << s));
			wait_call(20);
			chk(32'(n), 32'd8);
			chk(32'(core_o.vec), 32'(VEXP[s]));
			apb(1'b0, OFS_FLAGS, 32'h0);
			chk(rd, (s == 1 || s == 8) ? 32'(1 << s) : 32'h0);
			apb(1'b1, OFS_FLAGS, 32'h1fff);
			idle(14);
		end
	endtask : t_vectors

	// Simultaneous equal-level requests, prompt returns
	task automatic t_order;
		int ord [8] = '{0, 2, 3, 4, 5, 6, 7, 9};
		fire(12'h2fd);
		foreach (ord[i])
		begin
			wait_call(40);
			chk(32'(core_o.vec), 32'(VEXP[ord[i]]));
		end
		idle(10);
	endtask : t_order

	// All four levels, watchdog bit set; a higher group wins over poll order
	task automatic t_levels;
		for (int lv = 0; lv < 4; lv++)
		begin
			apb(1'b1, OFS_PRIO_HI, 32'(lv >> 1));
			apb(1'b1, OFS_PRIO_LO, 32'h40 | 32'(lv & 1));
			fire(12'h001);
			wait_call(20);
			chk(32'(core_o.lvl), 32'(lv));
			idle(14);
		end
		apb(1'b1, OFS_PRIO_HI, 32'h10);
		apb(1'b1, OFS_PRIO_LO, 32'h0);
		fire(12'h201);
		wait_call(20);
		chk(32'(core_o.vec), 32'h0063);
		wait_call(40);
		chk(32'(core_o.vec), 32'h0003);
		idle(14);
	endtask : t_levels

	// Equal level refused, higher preempts, lower waits for return
	task automatic t_preempt;
		hold <= 1'b1;
		apb(1'b1, OFS_PRIO_HI, 32'h04);
		apb(1'b1, OFS_PRIO_LO, 32'h04);
		fire(12'h001);
		wait_call(20);
		fire(12'h004);
		wait_call(20, 1'b0);
		chk(32'(n), 32'd20);
		fire(12'h010);
		wait_call(20);
		chk(32'(core_o.vec), 32'h0013);
		chk(32'(core_o.lvl), 32'd3);
		apb(1'b0, OFS_STATUS, 32'h0);
		chk(rd, 32'h0000_1333);
		hold <= 1'b0;
		wait_call(60);
		chk(32'(core_o.vec), 32'h000b);
		idle(14);
	endtask : t_preempt

	// A disabled source holds its flag but raises nothing until enabled
	task automatic t_enable;
		apb(1'b1, OFS_ENABLE, 32'h1ffe);
		fire(12'h001);
		wait_call(20, 1'b0);
		chk(32'(n), 32'd20);
		chk(32'(irq_o), 32'h0);
		apb(1'b0, OFS_FLAGS, 32'h0);
		chk(rd, 32'h1);
		apb(1'b1, OFS_ENABLE, 32'h1fff);
		idle(2);
		chk(32'(irq_o), 32'h1);
		wait_call(20);
		chk(32'(core_o.vec), 32'h0003);
		idle(2);
		chk(32'(irq_o), 32'h0);
		idle(14);
	endtask : t_enable

	// Transfer and tick requests reach ext6; software clears their flags
	task automatic t_ext6;
		for (int e = 0; e < 2; e++)
		begin
			fire(e ? 12'h800 : 12'h400);
			wait_call(20);
			chk(32'(core_o.vec), 32'h006b);
			apb(1'b0, OFS_FLAGS, 32'h0);
			chk(rd, e ? 32'h1400 : 32'h0c00);
			apb(1'b1, OFS_FLAGS, 32'h1c00);
			apb(1'b0, OFS_FLAGS, 32'h0);
			chk(rd, 32'h0);
			idle(14);
		end
	endtask : t_ext6

	// Reset in mid-call drops flags, enables and the pending call
	task automatic t_rst2;
		fire(12'h002);
		idle(3);
		presetn <= 1'b0;
		idle(2);
		presetn <= 1'b1;
		chk(32'(irq_o), 32'h0);
		apb(1'b0, OFS_FLAGS, 32'h0);
		chk(rd, 32'h0);
		apb(1'b0, OFS_ENABLE, 32'h0);
		chk(rd, 32'h0);
		fire(12'h001);
		wait_call(20, 1'b0);
		chk(32'(n), 32'd20);
		chk(32'(irq_o), 32'h0);
	endtask : t_rst2

	// Main sequence
	initial
	begin
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		t_reset;
		apb(1'b1, OFS_ENABLE, 32'h1fff);
		t_vectors;
		dly <= 4'd1;
		t_order;
		dly <= 4'd10;
		t_levels;
		t_preempt;
		t_enable;
		t_ext6;
		t_rst2;
		end_sim;
	end

endmodule : ivec_ctrl_test
